/* File: emb_pkg.sv */
// Package with constants and types for the external memory bus block.
// Summary of operation
// - Data bus floats except during external writes and suspend.
// - Data transfers and strobe only for external accesses.
// - Suspend drives every data line low.
// - Program strobe only on external fetches.
// - Strobe range depends on external select.
// - Low code from internal unless select high.
// - Match output when address equals enabled.
// - Pulse mode gives eight clock pulse.
// - Latched mode holds until write-one clear.
// - Reset clears the whole block.
// - Reset: address low, strobe high, float.
// - Address bus always driven.
// - Address pins mirror internal addresses too.
package emb_pkg;

  // ********************************************************************
  // Widths and address ranges.
  // ********************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // Top of the code range that stays internal unless external select is high.
  localparam logic [ADDR_W-1:0] INT_CODE_TOP = 16'h3fff;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // ********************************************************************
  // Register map of the plain register port.
  // ********************************************************************
  localparam int REG_AW = 3;
  localparam logic [REG_AW-1:0] OFS_MATCH_ADDR_LO = 3'h0;
  localparam logic [REG_AW-1:0] OFS_MATCH_ADDR_HI = 3'h1;
  localparam logic [REG_AW-1:0] OFS_MATCH_CTRL = 3'h2;
  localparam logic [REG_AW-1:0] OFS_IRQ_STATUS = 3'h3;
  localparam logic [REG_AW-1:0] OFS_IRQ_MASK = 3'h4;
  // Control register fields.
  localparam int BIT_MATCH_FLAG = 0;
  localparam int BIT_MATCH_ENABLE = 1;
  localparam int BIT_PULSE_MODE = 2;
  // Interrupt status fields.
  localparam int BIT_IRQ_MATCH = 0;
  localparam int BIT_IRQ_EXT = 1;
  localparam int IRQ_W = 2;
  localparam logic [IRQ_W-1:0] IRQ_ZERO = 2'h0;

  // ********************************************************************
  // Timing.
  // ********************************************************************
  // Pulse length in core clocks, so its duration scales with the core rate.
  localparam int PULSE_CLOCKS = 8;
  localparam int PCNT_W = 4;
  localparam logic [PCNT_W-1:0] PCNT_LOAD = PCNT_W'(PULSE_CLOCKS);
  localparam logic [PCNT_W-1:0] PCNT_ZERO = 4'h0;
  localparam logic [PCNT_W-1:0] PCNT_ONE = 4'h1;

  // ********************************************************************
  // Types.
  // ********************************************************************
  // One processor bus request from the core.
  typedef struct packed {
    logic valid;
    logic fetch;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } emb_req_t;

  // Register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [REG_AW-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } emb_reg_t;

  // External data pin pair: value and per-line output enable.
  typedef struct packed {
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] doe;
  } emb_dpin_t;

  // Bus cycle states.
  typedef enum logic [2:0] {
    EMB_IDLE = 3'b001,
    EMB_EXT = 3'b010,
    EMB_SUSP = 3'b100
  } emb_state_t;

endpackage : emb_pkg

/* File: emb_bus.sv */
// External memory bus and address match unit of the embedded core.
`timescale 1ns/1ps
`default_nettype none
module emb_bus
  import emb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire emb_pkg::emb_req_t core_req,
  input wire logic suspend,
  input wire logic external_code_select,
  input wire emb_pkg::emb_reg_t reg_req,
  output logic [emb_pkg::DATA_W-1:0] reg_rdata,
  output logic [emb_pkg::DATA_W-1:0] core_rdata,
  output logic core_ext_hit,
  output logic [emb_pkg::ADDR_W-1:0] ext_addr,
  input wire logic [emb_pkg::DATA_W-1:0] ext_data_in,
  output emb_pkg::emb_dpin_t ext_data_pin,
  output logic program_store_strobe_n,
  output logic match_indicator_out,
  output logic irq
);
  import emb_pkg::*;

  // ********************************************************************
  // Decode helpers.
  // ********************************************************************

  // True when a request leaves the chip; data space is always external
  // here, code space depends on the address and the external select.
  function automatic logic is_external(input emb_req_t r, input logic sel);
    if (!r.valid) begin
      is_external = 1'b0;
    end else if (r.fetch) begin
      is_external = sel || (r.addr > INT_CODE_TOP);
    end else begin
      is_external = 1'b1;
    end
  endfunction : is_external

  // ********************************************************************
  // Bus cycle state.
  // ********************************************************************
  emb_state_t state_r, state_nxt; // Current bus phase.
  logic [ADDR_W-1:0] addr_r, addr_nxt; // Address pin register.
  logic strobe_n_r, strobe_n_nxt; // Program strobe register.
  logic [DATA_W-1:0] dout_r, dout_nxt; // Data driven to pins.
  logic doe_r, doe_nxt; // Data output enable.
  logic [DATA_W-1:0] rdata_r, rdata_nxt; // Data captured on reads.
  logic read_r, read_nxt; // Current external cycle is a read.
  logic hit_r, hit_nxt; // One-cycle external completion.
  logic ext_now; // Request targets external space.

  assign ext_now = is_external(core_req, external_code_select);

  // Next-state logic for the bus; each request lasts one clock on pins.
  always_comb begin
    state_nxt = EMB_IDLE;
    addr_nxt = core_req.valid ? core_req.addr : addr_r;
    strobe_n_nxt = 1'b1;
    dout_nxt = DATA_ZERO;
    doe_nxt = 1'b0;
    read_nxt = 1'b0;
    rdata_nxt = rdata_r;
    hit_nxt = 1'b0;
    // A read finishing this clock captures the pins.
    if (state_r == EMB_EXT && read_r) begin
      rdata_nxt = ext_data_in;
    end
    case (state_r)
      // Waking from suspend serves a request in the same clock, so the
      // first access after wake is never lost.
      EMB_IDLE, EMB_EXT, EMB_SUSP: begin
        if (suspend) begin
          state_nxt = EMB_SUSP;
          doe_nxt = 1'b1;
        end else if (ext_now) begin
          state_nxt = EMB_EXT;
          doe_nxt = core_req.write && !core_req.fetch;
          dout_nxt = core_req.wdata;
          read_nxt = !doe_nxt;
          strobe_n_nxt = !core_req.fetch;
        end
        hit_nxt = (state_r == EMB_EXT);
      end
      default: begin
        state_nxt = EMB_IDLE;
      end
    endcase
  end

  // Registers of the bus; reset gives the documented quiet pin states.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= EMB_IDLE;
      addr_r <= ADDR_ZERO;
      strobe_n_r <= 1'b1;
      dout_r <= DATA_ZERO;
      doe_r <= 1'b0;
      read_r <= 1'b0;
      rdata_r <= DATA_ZERO;
      hit_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      strobe_n_r <= strobe_n_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      read_r <= read_nxt;
      rdata_r <= rdata_nxt;
      hit_r <= hit_nxt;
    end
  end

  assign ext_addr = addr_r;
  // One driver for the whole pin struct keeps the output variable legal.
  assign ext_data_pin = '{dout: dout_r, doe: {DATA_W{doe_r}}};
  assign program_store_strobe_n = strobe_n_r;
  assign core_rdata = rdata_r;
  assign core_ext_hit = hit_r;

  // ********************************************************************
  // Address match unit and registers.
  // ********************************************************************
  logic [ADDR_W-1:0] match_addr_r, match_addr_nxt; // Match address pair.
  logic enable_r, enable_nxt; // Match enable.
  logic pulse_mode_r, pulse_mode_nxt; // Pulse versus latched mode.
  logic flag_r, flag_nxt; // Sticky match flag.
  logic [PCNT_W-1:0] pcnt_r, pcnt_nxt; // Pulse clocks remaining.
  logic [IRQ_W-1:0] irq_stat_r, irq_stat_nxt; // Interrupt status.
  logic [IRQ_W-1:0] irq_mask_r, irq_mask_nxt; // Interrupt mask.
  logic [DATA_W-1:0] rdata_reg_r, rdata_reg_nxt; // Register read data.
  logic match_out_r, match_out_nxt; // Output pin register.
  logic match_ev; // Address equals match value.
  logic [IRQ_W-1:0] irq_ev; // Interrupt events.
  logic [IRQ_W-1:0] irq_clr; // Write-one-to-clear pattern.

  assign match_ev = enable_r && core_req.valid &&
                    (core_req.addr == match_addr_r);
  assign irq_ev = IRQ_W'({hit_nxt, match_ev});
  assign irq_clr = (reg_req.wr && reg_req.addr == OFS_IRQ_STATUS) ?
                   reg_req.wdata[IRQ_W-1:0] : IRQ_ZERO;

  // Register writes, match flag, pulse counter and reads.
  always_comb begin
    match_addr_nxt = match_addr_r;
    enable_nxt = enable_r;
    pulse_mode_nxt = pulse_mode_r;
    irq_mask_nxt = irq_mask_r;
    flag_nxt = flag_r;
    pcnt_nxt = (pcnt_r != PCNT_ZERO) ? pcnt_r - PCNT_ONE : PCNT_ZERO;
    rdata_reg_nxt = DATA_ZERO;
    if (reg_req.wr) begin
      case (reg_req.addr)
        OFS_MATCH_ADDR_LO: begin
          match_addr_nxt[DATA_W-1:0] = reg_req.wdata;
        end
        OFS_MATCH_ADDR_HI: begin
          match_addr_nxt[ADDR_W-1:DATA_W] = reg_req.wdata;
        end
        OFS_MATCH_CTRL: begin
          enable_nxt = reg_req.wdata[BIT_MATCH_ENABLE];
          pulse_mode_nxt = reg_req.wdata[BIT_PULSE_MODE];
          if (reg_req.wdata[BIT_MATCH_FLAG]) begin
            flag_nxt = 1'b0;
          end
        end
        OFS_IRQ_MASK: begin
          irq_mask_nxt = reg_req.wdata[IRQ_W-1:0];
        end
        default: begin
          // Unmapped or status writes store nothing here.
        end
      endcase
    end
    // A new match wins over a clear in the same clock.
    if (match_ev) begin
      flag_nxt = 1'b1;
      pcnt_nxt = PCNT_LOAD;
    end
    // Status is sticky, set beats write-one clear.
    irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_ev;
    // Pulse mode follows the counter; latched mode follows the flag.
    match_out_nxt = pulse_mode_nxt ? (pcnt_nxt != PCNT_ZERO) : flag_nxt;
    if (reg_req.rd) begin
      case (reg_req.addr)
        OFS_MATCH_ADDR_LO: rdata_reg_nxt = match_addr_r[DATA_W-1:0];
        OFS_MATCH_ADDR_HI: rdata_reg_nxt = match_addr_r[ADDR_W-1:DATA_W];
        OFS_MATCH_CTRL: begin
          rdata_reg_nxt[BIT_MATCH_FLAG] = flag_r;
          rdata_reg_nxt[BIT_MATCH_ENABLE] = enable_r;
          rdata_reg_nxt[BIT_PULSE_MODE] = pulse_mode_r;
        end
        OFS_IRQ_STATUS: rdata_reg_nxt[IRQ_W-1:0] = irq_stat_r;
        OFS_IRQ_MASK: rdata_reg_nxt[IRQ_W-1:0] = irq_mask_r;
        default: rdata_reg_nxt = DATA_ZERO;
      endcase
    end
  end

  // Registers of the match unit; output stays low through reset.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      match_addr_r <= ADDR_ZERO;
      enable_r <= 1'b0;
      pulse_mode_r <= 1'b0;
      flag_r <= 1'b0;
      pcnt_r <= PCNT_ZERO;
      irq_stat_r <= IRQ_ZERO;
      irq_mask_r <= IRQ_ZERO;
      rdata_reg_r <= DATA_ZERO;
      match_out_r <= 1'b0;
    end else begin
      match_addr_r <= match_addr_nxt;
      enable_r <= enable_nxt;
      pulse_mode_r <= pulse_mode_nxt;
      flag_r <= flag_nxt;
      pcnt_r <= pcnt_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      rdata_reg_r <= rdata_reg_nxt;
      match_out_r <= match_out_nxt;
    end
  end

  assign reg_rdata = rdata_reg_r;
  assign match_indicator_out = match_out_r;
  // Level interrupt while any unmasked status bit is set.
  assign irq = |(irq_stat_r & irq_mask_r);

endmodule : emb_bus
`default_nettype wire

/* File: emb_checker.sv */
// Assertion checker for the external memory bus block.
`timescale 1ns/1ps
`default_nettype none
module emb_checker
  import emb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire emb_pkg::emb_req_t core_req,
  input wire logic suspend,
  input wire logic external_code_select,
  input wire emb_pkg::emb_reg_t reg_req,
  input wire logic [emb_pkg::ADDR_W-1:0] ext_addr,
  input wire emb_pkg::emb_dpin_t ext_data_pin,
  input wire logic program_store_strobe_n,
  input wire logic match_indicator_out
);
  import emb_pkg::*;
  // ****************************************************************
  // Shadow registers: the checker sees no internal state.
  // ****************************************************************
  logic en_r;
  logic pm_r;
  logic [ADDR_W-1:0] ma_r;
  logic ext;
  logic clr;
  logic fv;
  assign ext = external_code_select || core_req.addr > INT_CODE_TOP;
  assign fv = core_req.valid && core_req.fetch;
  assign clr = reg_req.wr && reg_req.addr == OFS_MATCH_CTRL &&
               reg_req.wdata[BIT_MATCH_FLAG];
  // Track control and match address writes as the design takes them.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      en_r <= 1'b0;
      pm_r <= 1'b0;
      ma_r <= ADDR_ZERO;
    end else if (reg_req.wr) begin
      if (reg_req.addr == OFS_MATCH_CTRL) en_r <= reg_req.wdata[1];
      if (reg_req.addr == OFS_MATCH_CTRL) pm_r <= reg_req.wdata[2];
      if (reg_req.addr == OFS_MATCH_ADDR_LO) ma_r[7:0] <= reg_req.wdata;
      if (reg_req.addr == OFS_MATCH_ADDR_HI) ma_r[15:8] <= reg_req.wdata;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_idle; !core_req.valid && !suspend |=> ext_data_pin.doe == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("bus driven idle");
  property p_int; fv && !ext && !suspend |=> program_store_strobe_n &&
    ext_data_pin.doe == 8'h00; endproperty
  a_int: assert property (p_int) else $error("internal fetch out");
  property p_fetch; fv && ext && !suspend |=> !program_store_strobe_n;
  endproperty
  a_fetch: assert property (p_fetch) else $error("strobe missing");
  property p_data; !fv |=> program_store_strobe_n; endproperty
  a_data: assert property (p_data) else $error("strobe on data");
  property p_susp; suspend |=> ext_data_pin.doe == 8'hff &&
    ext_data_pin.dout == 8'h00; endproperty
  a_susp: assert property (p_susp) else $error("suspend not low");
  property p_mir; core_req.valid |=> ext_addr == $past(core_req.addr);
  endproperty
  a_mir: assert property (p_mir) else $error("address not mirrored");
  property p_match; core_req.valid && en_r && core_req.addr == ma_r |=>
    match_indicator_out; endproperty
  a_match: assert property (p_match) else $error("match missed");
  property p_pulse; $rose(match_indicator_out) && pm_r |->
    match_indicator_out [*8] ##1 !match_indicator_out; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse length");
  property p_latch; !pm_r && match_indicator_out && !clr |=>
    match_indicator_out; endproperty
  a_latch: assert property (p_latch) else $error("latch dropped");
  property p_rst; disable iff (1'b0) rst |-> ext_addr == ADDR_ZERO &&
    ext_data_pin.doe == 8'h00 && program_store_strobe_n &&
    !match_indicator_out; endproperty
  a_rst: assert property (p_rst) else $error("reset pin state");
endmodule : emb_checker
bind emb_bus emb_checker chk_u (.clk_sys, .rst, .core_req, .suspend,
  .external_code_select, .reg_req, .ext_addr, .ext_data_pin,
  .program_store_strobe_n, .match_indicator_out);
`default_nettype wire

/* File: emb_mem_model.sv */
// External program and data memory model facing the bus block.
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model
  import emb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [emb_pkg::ADDR_W-1:0] ext_addr,
  input wire emb_pkg::emb_dpin_t ext_data_pin,
  output logic [emb_pkg::DATA_W-1:0] ext_data_in,
  output logic [emb_pkg::DATA_W-1:0] wr_data
);
  // bus level: the block's drive wins, else the memory answers.
  always_comb begin
    if (ext_data_pin.doe == 8'h00) begin
      ext_data_in = ext_addr[7:0] ^ ext_addr[15:8] ^ 8'h5a;
    end else begin
      ext_data_in = ext_data_pin.dout;
    end
  end
  // Capture what the block writes, so the bench can compare it.
  always_ff @(posedge clk_sys) begin
    if (ext_data_pin.doe == 8'hff) wr_data <= ext_data_pin.dout;
  end
endmodule : emb_mem_model
`default_nettype wire

/* File: tb.sv */
// Self-checking testbench for the external memory bus block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import emb_pkg::*;
  logic clk_sys, rst, suspend, sel, pss_n, mout, irq, hit, f;
  emb_req_t req;
  emb_reg_t rr;
  emb_dpin_t dpin;
  logic [DATA_W-1:0] reg_rdata, core_rdata, din, wr_data;
  logic [ADDR_W-1:0] ext_addr;
  logic [ADDR_W-1:0] cor [4] = '{16'h0000, 16'h3fff, 16'h4000, 16'hffff};
  int num_errors = 0;
  int samples_checked = 0;
  int i;
  emb_bus dut_u (.clk_sys(clk_sys), .rst(rst), .core_req(req),
    .suspend(suspend), .external_code_select(sel), .reg_req(rr),
    .reg_rdata(reg_rdata), .core_rdata(core_rdata), .core_ext_hit(hit),
    .ext_addr(ext_addr), .ext_data_in(din), .ext_data_pin(dpin),
    .program_store_strobe_n(pss_n), .match_indicator_out(mout), .irq(irq));
  emb_mem_model mem_u (.clk_sys(clk_sys), .ext_addr(ext_addr),
    .ext_data_pin(dpin), .ext_data_in(din), .wr_data(wr_data));
  // Read data the memory should return for an address.
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : pat
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    rr <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    rr <= '0;
    #1;
  endtask : reg_wr
  task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    rr <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    rr <= '0;
    #1 chk(16'(reg_rdata), 16'(e));
  endtask : reg_rd
  // One core access; pins are checked in cycle 1, results in cycle 2.
  task automatic core_op(input logic s, input logic fe, input logic w,
    input logic [15:0] a, input logic [7:0] d);
    logic e;
    e = w || !fe || s || a > INT_CODE_TOP;
    @(posedge clk_sys);
    sel <= s;
    req <= '{1'b1, fe, w, a, d};
    @(posedge clk_sys);
    req.valid <= 1'b0;
    #1 chk(ext_addr, a);
    chk(16'(pss_n), 16'(!(fe && e)));
    chk(16'(dpin.doe), w ? 16'h00ff : 16'h0000);
    @(posedge clk_sys);
    #1 chk(16'(hit), 16'(e));
    if (e && !w) chk(16'(core_rdata), 16'(pat(a)));
    if (w) chk(16'(wr_data), 16'(d));
  endtask : core_op
  task automatic summarize();
    $display("Errors: %0d, checks: %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #40000;
    num_errors++;
    summarize();
  end
  initial begin
    {rst, suspend, sel, req, rr} = '0;
    rst = 1'b1;
    i = $urandom(32'ha737);
    repeat (16) @(posedge clk_sys);
    chk(ext_addr, ADDR_ZERO);
    chk({dpin.doe, 5'h00, pss_n, mout, irq}, 16'h0004);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) reg_rd(3'(i), 8'h00);
    reg_rd(3'h7, 8'h00);
    for (i = 0; i < 8; i++) core_op(i[0], 1'b1, 1'b0, cor[i/2], 8'h00);
    for (i = 0; i < 40; i++) begin
      f = 1'($urandom);
      core_op(1'($urandom), f, !f & 1'($urandom), 16'($urandom), 8'($urandom));
    end
    @(posedge clk_sys);
    suspend <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk({dpin.doe, dpin.dout}, 16'hff00);
    @(posedge clk_sys);
    suspend <= 1'b0;
    reg_wr(OFS_MATCH_ADDR_LO, 8'h34);
    reg_wr(OFS_MATCH_ADDR_HI, 8'h92);
    reg_wr(OFS_MATCH_CTRL, 8'h06);
    reg_rd(OFS_MATCH_CTRL, 8'h06);
    core_op(1'b0, 1'b0, 1'b0, 16'h9234, 8'h00);
    chk(16'(mout), 16'h0001);
    repeat (6) @(posedge clk_sys);
    #1 chk(16'(mout), 16'h0001);
    @(posedge clk_sys);
    #1 chk(16'(mout), 16'h0000);
    reg_wr(OFS_MATCH_CTRL, 8'h03);
    chk(16'(mout), 16'h0000);
    core_op(1'b0, 1'b0, 1'b1, 16'h9234, 8'ha5);
    repeat (20) @(posedge clk_sys);
    #1 chk(16'(mout), 16'h0001);
    reg_rd(OFS_MATCH_CTRL, 8'h03);
    reg_rd(OFS_IRQ_STATUS, 8'h03);
    reg_wr(OFS_IRQ_MASK, 8'h00);
    chk(16'(irq), 16'h0000);
    reg_wr(OFS_IRQ_MASK, 8'h03);
    chk(16'(irq), 16'h0001);
    reg_wr(OFS_IRQ_STATUS, 8'h03);
    chk(16'(irq), 16'h0000);
    reg_wr(OFS_MATCH_CTRL, 8'h03);
    @(posedge clk_sys);
    #1 chk(16'(mout), 16'h0000);
    reg_wr(OFS_MATCH_CTRL, 8'h00);
    core_op(1'b0, 1'b0, 1'b0, 16'h9234, 8'h00);
    chk(16'(mout), 16'h0000);
    reg_wr(OFS_MATCH_CTRL, 8'h02);
    core_op(1'b0, 1'b0, 1'b0, 16'h9234, 8'h00);
    chk(16'(mout), 16'h0001);
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    #1 chk(ext_addr, ADDR_ZERO);
    chk(16'({dpin.doe, pss_n, mout, irq}), 16'h0004);
    @(posedge clk_sys);
    rst <= 1'b0;
    reg_rd(OFS_MATCH_CTRL, 8'h00);
    reg_rd(OFS_IRQ_STATUS, 8'h00);
    summarize();
  end
endmodule : tb
`default_nettype wire
